// ===== include/crc_guard_pkg.sv
// Purpose: shared constants, types and register map of the buffer CRC guard
// Assumes: 7-bit link command space, 8-bit data, 8 pages x 16 rows x 4 bytes of EEPROM
// Notes: every offset, status and control bit position and count lives here, and all reset values but those of the flags, timer and outputs
package crc_guard_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CMD_W = 7;
  localparam int PAGE_W = 3;
  localparam int ROW_W = 4;
  localparam int BYTE_W = 2;
  localparam int ROW_BYTES = 4;
  localparam int EE_ADDR_W = PAGE_W + ROW_W + BYTE_W;
  localparam int EE_BYTES = 512;
  localparam int CRC_STEPS = 8;

  // ----------------------------------------------------------------
  // crc-8, x^8+x^5+x^4+1
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_SEED = 8'hff;

  // ----------------------------------------------------------------
  // register offsets (link command codes)
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_STATUS = 7'h04;
  localparam logic [6:0] OFS_CONTROL = 7'h05;
  localparam logic [6:0] OFS_PAGE = 7'h07;
  localparam logic [6:0] OFS_PKT_CRC = 7'h0c;
  localparam logic [6:0] OFS_ROW = 7'h0d;
  localparam logic [6:0] OFS_REV = 7'h0e;
  localparam logic [6:0] OFS_ID = 7'h0f;
  localparam logic [6:0] OFS_BUF_CRC = 7'h20;
  localparam logic [6:0] OFS_TARGET = 7'h21;
  localparam logic [6:0] OFS_CTRL2 = 7'h25;
  localparam logic [6:0] OFS_PAGE_EN = 7'h31;
  // buffer bytes sit at the bottom of the command space
  localparam logic [4:0] BUF_CMD_HI = 5'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MAPPED_BIT = 6;
  localparam int ST_BUFFER_CRC_ERROR_FLAG_BIT = 0;
  localparam int ST_MEM_ERR_BIT = 1;
  localparam int ST_MEM_WR_BIT = 4;
  localparam int ST_PAGE_ENABLE_ERROR_FLAG_BIT = 5;
  localparam int CTL_ERROR_CLEAR_BIT_BIT = 4;
  localparam int CTL2_UNLOCK_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and fixed locations
  // ----------------------------------------------------------------
  localparam logic [7:0] PKT_CRC_RST = 8'h00;
  localparam logic [3:0] ROW_RST = 4'h0;
  localparam logic [2:0] PAGE_RST = 3'h0;
  localparam logic [7:0] TARGET_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] PAGE_EN_RST = 8'h00;
  localparam logic [2:0] MFG_PAGE = 3'h0;
  // manufacturer area 0x30..0x3f is rows 12..15 of page 0
  localparam logic [3:0] MFG_ROW_FIRST = 4'hc;
  localparam logic [8:0] EE_PAGE_EN_ADDR = 9'h031;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PROG_CYCLES_DEF = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [6:0] cmd;
    logic [7:0] data;
  } packet_s;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_PROG = 2'b10,
    ST_VERIFY = 2'b11
  } guard_state_e;

endpackage

// ===== hw/crc8_byte_step.sv
// Purpose: one combinational crc-8 byte update, msb first
// Assumes: caller supplies the running value or the seed as prev_i
// Notes: eight unrolled shift steps, one per generate iteration
`timescale 1ns/1ps
module crc8_byte_step
  import crc_guard_pkg::*;
(
  input wire logic [7:0] prev_i,
  input wire logic [7:0] data_i,
  output logic [7:0] crc_o
);

  // ----------------------------------------------------------------
  // shift chain
  // ----------------------------------------------------------------
  logic [7:0] stage [CRC_STEPS+1];

  // data folds into the previous result before any shift
  assign stage[0] = prev_i ^ data_i;

  for (genvar i = 0; i < CRC_STEPS; i++) begin : g_step
    assign stage[i+1] = stage[i][7] ? ({stage[i][6:0], 1'b0} ^ CRC_POLY) : {stage[i][6:0], 1'b0};
  end

  assign crc_o = stage[CRC_STEPS];

endmodule

// ===== hw/eeprom_buffer_crc_guard.sv
// Purpose: packet crc, buffer crc guard and write protection of a small serial EEPROM
// Assumes: link bit timing lives outside; one decoded packet arrives per PKT_VALID_I pulse
// Notes: EEPROM array is held here; program and read-back verify run from a state machine
`timescale 1ns/1ps
module eeprom_buffer_crc_guard
  import crc_guard_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF,
  parameter logic [7:0] HW_REVISION = 8'h07, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h5a // arbitrary value
)
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PKT_VALID_I,
  input wire packet_s PKT_I,
  output logic RD_VALID_O,
  output logic [7:0] RD_DATA_O,
  output logic PROG_BUSY_O
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // nonvolatile contents are not reset; that is what makes them nonvolatile
  logic [7:0] eeprom [EE_BYTES];
  logic [7:0] buffer [ROW_BYTES];

  guard_state_e state;
  guard_state_e next_state;
  logic [15:0] prog_count;

  logic [7:0] pkt_crc;
  logic [7:0] buf_crc;
  logic [7:0] crc_target;
  logic [7:0] ctrl2;
  logic [7:0] page_en;
  logic [2:0] page;
  logic [3:0] row;
  logic mem_wr;
  logic buffer_crc_error_flag;
  logic mem_err;
  logic page_enable_error_flag;

  // ----------------------------------------------------------------
  // packet decode
  // ----------------------------------------------------------------
  wire idle = (state == ST_IDLE);
  wire is_write = PKT_I.write;
  wire [6:0] cmd = PKT_I.cmd;
  wire [7:0] wdata = PKT_I.data;
  wire [3:0] acc_row = cmd[5:2];
  wire [1:0] acc_byte = cmd[1:0];
  wire is_mapped = cmd[MAPPED_BIT];
  wire is_buf_cmd = !is_mapped && (cmd[6:2] == BUF_CMD_HI);

  // memory-side accesses are only taken while no program cycle is running
  wire map_hit = PKT_VALID_I && idle && is_mapped;
  wire buf_hit = PKT_VALID_I && idle && is_buf_cmd;
  wire byte_xfer = map_hit || buf_hit;
  wire reg_wr = PKT_VALID_I && is_write;
  wire target_wr = reg_wr && idle && (cmd == OFS_TARGET);
  wire ctrl_wr = reg_wr && (cmd == OFS_CONTROL);
  wire ctrl2_wr = reg_wr && (cmd == OFS_CTRL2);
  wire page_wr = reg_wr && (cmd == OFS_PAGE);
  wire unlock = ctrl2[CTL2_UNLOCK_BIT];
  wire page_en_wr = reg_wr && (cmd == OFS_PAGE_EN) && unlock;
  wire err_clear = ctrl_wr && wdata[CTL_ERROR_CLEAR_BIT_BIT];

  // ----------------------------------------------------------------
  // eeprom addressing
  // ----------------------------------------------------------------
  // page pointer selects page
  wire [EE_ADDR_W-1:0] map_addr = {page, acc_row, acc_byte};
  wire [EE_ADDR_W-1:0] row_base = {page, row, 2'b00};
  wire [7:0] map_byte = eeprom[map_addr];

  // byte that crosses the link on a buffer or mapped access
  wire [7:0] xfer_byte = is_write ? wdata : (is_mapped ? map_byte : buffer[acc_byte]);

  // ----------------------------------------------------------------
  // crc engines
  // ----------------------------------------------------------------
  logic [7:0] pkt_head_rev;
  logic [7:0] pkt_data_rev;
  logic [7:0] pkt_crc_mid;
  logic [7:0] pkt_crc_new;
  logic [7:0] buf_crc_new;

  // lsb-first arrival order
  // command bit 0 must land in bit 7 so it is shifted first; read/write bit goes last
  assign pkt_head_rev = {<<{is_write, cmd}};
  assign pkt_data_rev = {<<{wdata}};

  crc8_byte_step u_pkt_head (
    .prev_i(CRC_SEED),
    .data_i(pkt_head_rev),
    .crc_o(pkt_crc_mid)
  );

  crc8_byte_step u_pkt_data (
    .prev_i(pkt_crc_mid),
    .data_i(pkt_data_rev),
    .crc_o(pkt_crc_new)
  );

  wire [7:0] buf_crc_prev = map_hit ? CRC_SEED : buf_crc;

  crc8_byte_step u_buf (
    .prev_i(buf_crc_prev),
    .data_i(xfer_byte),
    .crc_o(buf_crc_new)
  );

  // ----------------------------------------------------------------
  // target comparison and protection
  // ----------------------------------------------------------------
  // compare target with result
  wire crc_match = (wdata == buf_crc);
  wire in_mfg_area = (page == MFG_PAGE) && (row >= MFG_ROW_FIRST);
  wire page_ok = page_en[page] && (!in_mfg_area || unlock);
  // programming only after a passed check
  wire start_prog = target_wr && crc_match && mem_wr && page_ok;
  wire pgen_fail = target_wr && crc_match && mem_wr && !page_ok;
  wire crc_fail = target_wr && !crc_match;
  wire prog_done = (state == ST_PROG) && (prog_count == 16'(PROG_CYCLES - 1));

  // read back and compare the whole row
  logic verify_bad;
  always_comb begin
    verify_bad = 1'b0;
    for (int b = 0; b < ROW_BYTES; b++) begin
      if (eeprom[row_base + EE_ADDR_W'(b)] != buffer[b]) begin
        verify_bad = 1'b1;
      end
    end
  end
  wire verify_fail = (state == ST_VERIFY) && verify_bad;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // load state runs once after reset to fetch the page enables
  always_comb begin
    next_state = state;
    unique case (state)
      ST_LOAD: begin
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (start_prog) begin
          next_state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (prog_done) begin
          next_state = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state and program timer
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state <= ST_LOAD;
      prog_count <= 16'h0000;
    end else begin
      state <= next_state;
      prog_count <= (state == ST_PROG) ? prog_count + 16'h0001 : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // eeprom array and staging buffer
  // ----------------------------------------------------------------
  // program buffer into row
  always_ff @(posedge CLK_I) begin
    if (prog_done) begin
      for (int b = 0; b < ROW_BYTES; b++) begin
        eeprom[row_base + EE_ADDR_W'(b)] <= buffer[b];
      end
    end
  end

  // mapped access fetches the row, a write then pokes one byte
  always_ff @(posedge CLK_I) begin
    for (int b = 0; b < ROW_BYTES; b++) begin
      if (map_hit) begin
        buffer[b] <= (is_write && (acc_byte == 2'(b))) ? wdata : eeprom[{page, acc_row, 2'(b)}];
      end else if (buf_hit && is_write && (acc_byte == 2'(b))) begin
        buffer[b] <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // crc registers
  // ----------------------------------------------------------------
  // buffer result has no defined reset; seed keeps it deterministic
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pkt_crc <= PKT_CRC_RST;
      buf_crc <= CRC_SEED;
      crc_target <= TARGET_RST;
    end else begin
      if (PKT_VALID_I) begin
        pkt_crc <= pkt_crc_new;
      end
      if (byte_xfer) begin
        buf_crc <= buf_crc_new;
      end
      if (target_wr) begin
        crc_target <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // page enables reset to PAGE_EN_RST, then the load state fetches them
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ctrl2 <= CTRL2_RST;
      page <= PAGE_RST;
      row <= ROW_RST;
      page_en <= PAGE_EN_RST;
    end else begin
      if (ctrl2_wr) begin
        ctrl2 <= wdata;
      end
      if (page_wr) begin
        page <= wdata[PAGE_W-1:0];
      end
      if (map_hit) begin
        row <= acc_row;
      end
      if (state == ST_LOAD) begin
        page_en <= eeprom[EE_PAGE_EN_ADDR];
      end else if (page_en_wr) begin
        page_en <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // a setting event in the clearing cycle wins, so no error is lost
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mem_wr <= 1'b0;
      buffer_crc_error_flag <= 1'b0;
      mem_err <= 1'b0;
      page_enable_error_flag <= 1'b0;
    end else begin
      if (map_hit) begin
        mem_wr <= is_write;
      end else if (prog_done) begin
        mem_wr <= 1'b0;
      end
      buffer_crc_error_flag <= crc_fail | (buffer_crc_error_flag & ~err_clear);
      mem_err <= verify_fail | (mem_err & ~err_clear);
      page_enable_error_flag <= pgen_fail | (page_enable_error_flag & ~err_clear);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_BUFFER_CRC_ERROR_FLAG_BIT] = buffer_crc_error_flag;
    status_byte[ST_MEM_ERR_BIT] = mem_err;
    status_byte[ST_MEM_WR_BIT] = mem_wr;
    status_byte[ST_PAGE_ENABLE_ERROR_FLAG_BIT] = page_enable_error_flag;
  end

  wire [7:0] rd_mux =
    is_mapped ? map_byte :
    is_buf_cmd ? buffer[acc_byte] :
    (cmd == OFS_STATUS) ? status_byte :
    (cmd == OFS_PAGE) ? {5'h00, page} :
    (cmd == OFS_PKT_CRC) ? pkt_crc :
    (cmd == OFS_ROW) ? {4'h0, row} :
    (cmd == OFS_REV) ? HW_REVISION :
    (cmd == OFS_ID) ? PART_ID :
    (cmd == OFS_BUF_CRC) ? buf_crc :
    (cmd == OFS_TARGET) ? crc_target :
    (cmd == OFS_CTRL2) ? ctrl2 :
    (cmd == OFS_PAGE_EN) ? page_en :
    8'h00;

  // answer registered one cycle after the read packet
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      RD_VALID_O <= 1'b0;
      RD_DATA_O <= 8'h00;
      PROG_BUSY_O <= 1'b1;
    end else begin
      RD_VALID_O <= PKT_VALID_I && !is_write;
      if (PKT_VALID_I && !is_write) begin
        RD_DATA_O <= rd_mux;
      end
      PROG_BUSY_O <= (next_state != ST_IDLE);
    end
  end

endmodule

// ===== bench/guard_monitor.sv
// Purpose: port checks of the buffer crc guard
// Assumes: reads answered one cycle after the packet
// Notes: busy bounds hold for program counts of 1 to 8
`timescale 1ns/1ps
module guard_monitor
  import crc_guard_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF,
  parameter logic [7:0] HW_REVISION = 8'h07,
  parameter logic [7:0] PART_ID = 8'h5a
)
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PKT_VALID_I,
  input wire packet_s PKT_I,
  input wire logic RD_VALID_O,
  input wire logic [7:0] RD_DATA_O,
  input wire logic PROG_BUSY_O
);
  // --------------------------------
  // decode and target shadow
  // --------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic rd_req = PKT_VALID_I && !PKT_I.write;
  wire logic tgt_wr = PKT_VALID_I && PKT_I.write && PKT_I.cmd == OFS_TARGET;
  logic [7:0] tgt_seen;
  // target writes while busy are refused, so the shadow skips them as well
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      tgt_seen <= TARGET_RST;
    end else if (tgt_wr && !PROG_BUSY_O) begin
      tgt_seen <= PKT_I.data;
    end
  end

  // --------------------------------
  // checks
  // --------------------------------
  chk_map_answer: assert property (rd_req && PKT_I.cmd[MAPPED_BIT] |=> RD_VALID_O)
    else $error("mapped read not answered");
  chk_rev_code: assert property (rd_req && PKT_I.cmd == OFS_REV |=> RD_DATA_O == HW_REVISION)
    else $error("revision code wrong");
  chk_id_code: assert property (rd_req && PKT_I.cmd == OFS_ID |=> RD_DATA_O == PART_ID)
    else $error("part identifier wrong");
  chk_row_high: assert property (rd_req && PKT_I.cmd == OFS_ROW |=> RD_VALID_O && RD_DATA_O[7:4] == 4'h0)
    else $error("row register upper bits set");
  chk_target_back: assert property (rd_req && PKT_I.cmd == OFS_TARGET |=> RD_DATA_O == tgt_seen)
    else $error("target read differs from last write");
  chk_prog_cause: assert property ($rose(PROG_BUSY_O) && $past(RST_N_I) |-> $past(tgt_wr))
    else $error("program started without target write");
  chk_prog_span: assert property ($rose(PROG_BUSY_O) && $past(RST_N_I) |-> PROG_BUSY_O [*2] ##[1:8] !PROG_BUSY_O)
    else $error("program and verify length wrong");
  chk_load_span: assert property ($rose(RST_N_I) |-> PROG_BUSY_O ##[1:3] !PROG_BUSY_O)
    else $error("post reset load length wrong");
endmodule

bind eeprom_buffer_crc_guard guard_monitor #(.PROG_CYCLES(PROG_CYCLES), .HW_REVISION(HW_REVISION),
  .PART_ID(PART_ID)) mon (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PKT_VALID_I(PKT_VALID_I), .PKT_I(PKT_I),
  .RD_VALID_O(RD_VALID_O), .RD_DATA_O(RD_DATA_O), .PROG_BUSY_O(PROG_BUSY_O));

// ===== bench/host_link_model.sv
// Purpose: host gauge processor on the packet side of the link
// Assumes: one packet per pulse, answer one cycle later
// Notes: stale packet bits are inverted once the pulse drops
`timescale 1ns/1ps
module host_link_model
  import crc_guard_pkg::*;
(
  input wire logic clk_i,
  output logic pkt_valid_o,
  output packet_s pkt_o,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i
);
  // --------------------------------
  // host side helpers
  // --------------------------------
  initial begin
    pkt_valid_o = 1'b0;
    pkt_o = '0;
  end
  function automatic logic [7:0] crc8(input logic [7:0] prev, input logic [7:0] data);
    logic [7:0] c;
    c = data ^ prev;
    for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h31) : (c << 1);
    return c;
  endfunction
  // a gap cycle between packets keeps each drive to one per step
  task automatic send(input logic w, input logic [6:0] c, input logic [7:0] d);
    @(posedge clk_i);
    pkt_valid_o <= 1'b1;
    pkt_o <= '{w, c, d};
    @(posedge clk_i);
    pkt_valid_o <= 1'b0;
    pkt_o <= packet_s'(~pkt_o);
  endtask
  task automatic read(input logic [6:0] c, output logic v, output logic [7:0] d);
    send(1'b0, c, 8'h00);
    #1;
    v = rd_valid_i;
    d = rd_data_i;
  endtask
  // seed, precompute, then fetch and poke
  task automatic write_row(input logic [3:0] r, input logic [31:0] b, output logic [7:0] c);
    c = 8'hff;
    for (int i = 0; i < 4; i++) c = crc8(c, b[8*i+:8]);
    for (int i = 0; i < 4; i++) send(1'b1, i == 0 ? {1'b1, r, 2'b00} : 7'(i), b[8*i+:8]);
  endtask
endmodule

// ===== bench/eeprom_buffer_crc_guard_bench.sv
// Purpose: self-checking bench of the buffer crc guard
// Assumes: program count shortened to 2 cycles
// Notes: eeprom starts unknown, only rows written here are read back
`timescale 1ns/1ps
module eeprom_buffer_crc_guard_bench;
  import crc_guard_pkg::*;
  localparam logic [7:0] REV = 8'h13; // arbitrary value
  localparam logic [7:0] PID = 8'h6c; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pkt_valid;
  packet_s pkt;
  logic rd_valid;
  logic [7:0] rd_data;
  logic busy;
  logic [7:0] lfsr = 8'h4a;
  int errors = 0;
  int total_checks = 0;

  // --------------------------------
  // clock, design and host
  // --------------------------------
  always #20 clk = ~clk;
  eeprom_buffer_crc_guard #(.PROG_CYCLES(2), .HW_REVISION(REV), .PART_ID(PID)) DUT (.CLK_I(clk),
    .RST_N_I(rst_n), .PKT_VALID_I(pkt_valid), .PKT_I(pkt), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data),
    .PROG_BUSY_O(busy));
  host_link_model host (.clk_i(clk), .pkt_valid_o(pkt_valid), .pkt_o(pkt), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data));

  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  // link order: command low bit first, then read/write, then data low bit first
  function automatic logic [7:0] pkt_crc(input logic w, input logic [6:0] c, input logic [7:0] d);
    logic [7:0] a;
    logic [7:0] b;
    a = {<<{w, c}};
    b = {<<{d}};
    return host.crc8(host.crc8(8'hff, a), b);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [6:0] c, input logic [7:0] e);
    logic v;
    logic [7:0] d;
    host.read(c, v, d);
    check({v, d}, {1'b1, e});
  endtask
  // target write, then a bounded wait for program and verify
  task automatic tgt(input logic [7:0] c, input logic eb);
    int n;
    host.send(1'b1, OFS_TARGET, c);
    #1;
    check(busy, eb);
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      errors++;
      final_report();
    end
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    logic [7:0] c;
    logic [7:0] d;
    logic [6:0] a;
    logic [3:0] r;
    logic [31:0] b;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_REV, REV);
    rd(OFS_ID, PID);
    rd(OFS_ROW, 8'h00);
    rd(OFS_TARGET, 8'h00);
    $display("fixed registers done");
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      a = {3'b001, d[3:0]};
      d = rnd();
      host.send(1'b1, a, d);
      rd(OFS_PKT_CRC, pkt_crc(1'b1, a, d));
      rd(a, 8'h00);
      rd(OFS_PKT_CRC, pkt_crc(1'b0, a, 8'h00));
    end
    $display("packet crc done");
    host.send(1'b1, OFS_CTRL2, 8'h01);
    host.send(1'b1, OFS_PAGE_EN, 8'hfe);
    rd(OFS_PAGE_EN, 8'hfe);
    host.send(1'b1, OFS_CTRL2, 8'h00);
    host.send(1'b1, OFS_PAGE_EN, 8'hff);
    rd(OFS_PAGE_EN, 8'hfe);
    host.send(1'b1, OFS_PAGE, 8'h01);
    rd(OFS_PAGE, 8'h01);
    $display("page enables done");
    for (int k = 0; k < 3; k++) begin
      d = rnd();
      r = d[3:0];
      b = {rnd(), rnd(), rnd(), rnd()};
      host.write_row(r, b, c);
      rd(OFS_BUF_CRC, c);
      rd(OFS_STATUS, 8'h10);
      tgt(c, 1'b1);
      rd(OFS_STATUS, 8'h00);
      rd(OFS_TARGET, c);
      rd(OFS_ROW, {4'h0, r});
      for (int i = 0; i < 4; i++) begin
        rd(i == 0 ? {1'b1, r, 2'b00} : 7'(i), b[8*i+:8]);
      end
      rd(OFS_BUF_CRC, c);
      tgt(c, 1'b0);
      rd(OFS_STATUS, 8'h00);
    end
    $display("program and read back done");
    host.write_row(r, ~b, c);
    tgt(c ^ 8'h01, 1'b0);
    rd(OFS_STATUS, 8'h11);
    host.send(1'b1, OFS_CONTROL, 8'h10);
    rd(OFS_STATUS, 8'h10);
    rd({1'b1, r, 2'b01}, b[15:8]);
    $display("crc mismatch done");
    host.send(1'b1, OFS_PAGE, 8'h00);
    host.write_row(r, b, c);
    tgt(c, 1'b0);
    rd(OFS_STATUS, 8'h30);
    host.send(1'b1, OFS_CONTROL, 8'h10);
    rd(OFS_STATUS, 8'h10);
    $display("disabled page done");
    // unlocked write of the enables byte in the manufacturer rows, then a second reset reloads it
    host.send(1'b1, OFS_CTRL2, 8'h01);
    host.send(1'b1, OFS_PAGE_EN, 8'h01);
    b = {rnd(), rnd(), rnd(), rnd()};
    host.write_row(MFG_ROW_FIRST, b, c);
    tgt(c, 1'b1);
    rd(OFS_STATUS, 8'h00);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_PAGE_EN, b[15:8]);
    rd(OFS_CTRL2, 8'h00);
    $display("enable reload done");
    final_report();
  end
endmodule
